// File: hw/embst_pkg.sv
// Shared types and constants of the external memory bus strobe sequencer
package embst_pkg;
  localparam int EMBST_WAIT_W = 5;
  localparam logic [4:0] EMBST_RD_WAIT_RST = 5'h1f;
  localparam logic [4:0] EMBST_RD_DELAY_RST = 5'h01;
  localparam logic [4:0] EMBST_WR_WAIT_RST = 5'h1f;
  localparam logic [4:0] EMBST_WR_DELAY_RST = 5'h00;
  localparam logic [1:0] EMBST_ALE_LEN_RST = 2'h1;
  localparam logic EMBST_RATIO_HALF = 1'b0;
  localparam int EMBST_ADDR_W = 24;
  localparam int EMBST_DATA_W = 16;

  // Timing setup, held steady by software between cycles
  typedef struct packed {
    logic full_rate;
    logic mux16;
    logic [1:0] ale_len;
    logic [4:0] read_wait_count;
    logic [4:0] read_assert_delay;
    logic [4:0] write_wait_count;
    logic [4:0] write_assert_delay;
  } embst_cfg_s;

  typedef struct packed {
    logic chip_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic ale;
    logic [EMBST_ADDR_W-1:0] addr;
    logic [EMBST_DATA_W-1:0] wdata;
    logic data_oe_n;
  } embst_pins_s;

  typedef enum logic [2:0] {ST_IDLE, ST_ALE, ST_DLY, ST_STROBE, ST_HOLD} embst_state_e;
endpackage : embst_pkg

// File: hw/embst_clkdiv.sv
// Bus clock enable divider
`timescale 1ns/1ps
module embst_clkdiv (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic full_rate,
  output logic bclk_en,
  output logic half_en
);
  import embst_pkg::*;
  typedef struct packed {logic ph;} embst_div_s;
  embst_div_s q;
  embst_div_s next_q;

  always_comb begin
    next_q = q;
    next_q.ph = ~q.ph;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Full rate: every cycle is a bus clock; half rate: every other one
  assign bclk_en = full_rate | q.ph;
  // Mid point of a bus clock, used for half-bus-clock hold
  assign half_en = full_rate | ~q.ph;
endmodule : embst_clkdiv

// File: hw/embst_seq.sv
// External memory bus strobe sequencer, top level
`timescale 1ns/1ps
// Behaviour
// - The bus clock is the system clock times a ratio that resets to one half and may be set to one.
// - The read strobe lasts read wait count minus read assert delay plus one bus clocks, wait count default 1Fh.
// - The read strobe follows chip select by the read assert delay, default 1 bus clock; with mux16 the delay starts when the latch enable ends.
// - The address latch enable pulse lasts one to three bus clocks, default one.
// - Chip select rises on the same bus clock edge that ends the read strobe.
// - The write strobe lasts write wait count minus write assert delay plus one bus clocks, default 1Fh.
// - The write strobe follows chip select by the write assert delay, default 0; with mux16 the delay starts when the latch enable ends.
// - A 16-bit write to an 8-bit bus runs as two write cycles, each with its own address phase.
module embst_seq (
  input wire logic clk_sys,
  input wire logic nrst,
  input embst_pkg::embst_cfg_s cfg,
  input wire logic req,
  input wire logic req_write,
  input wire logic req_wide,
  input wire logic [embst_pkg::EMBST_ADDR_W-1:0] req_addr,
  input wire logic [embst_pkg::EMBST_DATA_W-1:0] req_wdata,
  input wire logic [embst_pkg::EMBST_DATA_W-1:0] bus_rdata,
  output logic busy,
  output logic done,
  output logic [embst_pkg::EMBST_DATA_W-1:0] rdata,
  output embst_pkg::embst_pins_s pins
);
  import embst_pkg::*;

  typedef struct packed {
    embst_state_e st;
    logic [5:0] cnt;
    logic wr;
    logic second;
    logic split;
    logic [EMBST_ADDR_W-1:0] addr;
    logic [EMBST_DATA_W-1:0] wdata;
    logic done;
    logic [EMBST_DATA_W-1:0] rdata;
    embst_pins_s pins;
  } embst_state_s;

  embst_state_s q;
  embst_state_s next_q;
  logic bclk_en;
  logic half_en;

  embst_clkdiv u_div (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .full_rate(cfg.full_rate),
    .bclk_en(bclk_en),
    .half_en(half_en)
  );

  // Strobe length in bus clocks; zero or negative spans clamp to one
  function automatic logic [5:0] strobe_len(input logic [4:0] waitc, input logic [4:0] dly);
    logic [5:0] d;
    d = {1'b0, waitc} - {1'b0, dly};
    if (waitc < dly) begin
      strobe_len = 6'h01;
    end else begin
      strobe_len = d + 6'h01;
    end
  endfunction : strobe_len

  // Byte address of the current phase, bit 0 set for the upper byte
  function automatic logic [EMBST_ADDR_W-1:0] phase_addr(input logic [EMBST_ADDR_W-1:0] a, input logic hi);
    phase_addr = a | {{(EMBST_ADDR_W-1){1'b0}}, hi};
  endfunction : phase_addr

  logic [4:0] dly_sel;
  assign dly_sel = q.wr ? cfg.write_assert_delay : cfg.read_assert_delay;

  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (req && bclk_en) begin
          next_q.wr = req_write;
          next_q.split = req_write & req_wide & ~cfg.mux16;
          next_q.second = 1'b0;
          next_q.addr = req_addr;
          next_q.wdata = req_wdata;
          next_q.pins.addr = req_addr;
          next_q.pins.wdata = req_wdata;
          next_q.pins.data_oe_n = ~req_write;
          next_q.pins.chip_select_n = 1'b0;
          next_q.pins.ale = cfg.mux16;
          next_q.cnt = {4'h0, cfg.ale_len};
          next_q.st = cfg.mux16 ? ST_ALE : ST_DLY;
          if (!cfg.mux16) begin
            next_q.cnt = {1'b0, req_write ? cfg.write_assert_delay : cfg.read_assert_delay};
            // Zero delay: strobe falls on the same edge as chip select
            if ((req_write ? cfg.write_assert_delay : cfg.read_assert_delay) == 5'h00) begin
              next_q.st = ST_STROBE;
              next_q.pins.write_strobe_n = ~req_write;
              next_q.pins.read_strobe_n = req_write;
              if (req_write) begin
                next_q.cnt = strobe_len(cfg.write_wait_count, cfg.write_assert_delay);
              end else begin
                next_q.cnt = strobe_len(cfg.read_wait_count, cfg.read_assert_delay);
              end
            end
          end
        end
      end
      ST_ALE: begin
        if (bclk_en) begin
          if (q.cnt <= 6'h01) begin
            next_q.pins.ale = 1'b0;
            next_q.cnt = {1'b0, dly_sel};
            next_q.st = ST_DLY;
          end else begin
            next_q.cnt = q.cnt - 6'h01;
          end
        end
      end
      ST_DLY: begin
        // Delay counted from entry to this state; zero strobes on the next clock, without waiting for a bus clock
        if (q.cnt == 6'h00 || (bclk_en && q.cnt == 6'h01)) begin
          next_q.st = ST_STROBE;
          if (q.wr) begin
            next_q.pins.write_strobe_n = 1'b0;
            next_q.cnt = strobe_len(cfg.write_wait_count, cfg.write_assert_delay);
          end else begin
            next_q.pins.read_strobe_n = 1'b0;
            next_q.cnt = strobe_len(cfg.read_wait_count, cfg.read_assert_delay);
          end
        end else if (bclk_en) begin
          next_q.cnt = q.cnt - 6'h01;
        end
      end
      ST_STROBE: begin
        if (bclk_en) begin
          if (q.cnt <= 6'h01) begin
            if (q.wr) begin
              next_q.pins.write_strobe_n = 1'b1;
              next_q.st = ST_HOLD;
            end else begin
              // Data sampled while strobe still low
              next_q.rdata = bus_rdata;
              next_q.pins.read_strobe_n = 1'b1;
              next_q.pins.chip_select_n = 1'b1;
              next_q.done = 1'b1;
              next_q.st = ST_IDLE;
            end
          end else begin
            next_q.cnt = q.cnt - 6'h01;
          end
        end
      end
      ST_HOLD: begin
        if (half_en && !bclk_en || cfg.full_rate) begin
          next_q.pins.chip_select_n = 1'b1;
          next_q.pins.data_oe_n = 1'b1;
          if (q.split && !q.second) begin
            next_q.second = 1'b1;
            next_q.st = ST_IDLE;
            // Continue with upper byte from the delay state, chip select held low
            next_q.pins.chip_select_n = 1'b0;
            next_q.pins.data_oe_n = 1'b0;
            next_q.pins.addr = phase_addr(q.addr, 1'b1);
            next_q.pins.wdata = {8'h00, q.wdata[EMBST_DATA_W-1:8]};
            next_q.cnt = {1'b0, cfg.write_assert_delay};
            next_q.st = ST_DLY;
          end else begin
            next_q.done = 1'b1;
            next_q.st = ST_IDLE;
          end
        end
      end
      default: begin
        next_q.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q.st <= ST_IDLE;
      q.cnt <= '0;
      q.wr <= 1'b0;
      q.second <= 1'b0;
      q.split <= 1'b0;
      q.addr <= '0;
      q.wdata <= '0;
      q.done <= 1'b0;
      q.rdata <= '0;
      q.pins <= '{chip_select_n: 1'b1, read_strobe_n: 1'b1, write_strobe_n: 1'b1, ale: 1'b0,
                  addr: '0, wdata: '0, data_oe_n: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign busy = (q.st != ST_IDLE);
  assign done = q.done;
  assign rdata = q.rdata;
  assign pins = q.pins;

  // ==========================================================
  // Checks
  property p_cs_with_rd;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(pins.read_strobe_n) |-> $rose(pins.chip_select_n);
  endproperty
  a_cs_with_rd: assert property (p_cs_with_rd) else $error("chip select not released with read strobe");

  property p_rd_under_cs;
    @(posedge clk_sys) disable iff (!nrst)
    !pins.read_strobe_n |-> !pins.chip_select_n;
  endproperty
  a_rd_under_cs: assert property (p_rd_under_cs) else $error("read strobe outside chip select");

  property p_wr_hold;
    @(posedge clk_sys) disable iff (!nrst)
    $rose(pins.write_strobe_n) |-> !pins.chip_select_n;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("no hold after write strobe");

  property p_wr_delay0;
    @(posedge clk_sys) disable iff (!nrst)
    ($fell(pins.chip_select_n) && q.wr && cfg.write_assert_delay == 5'h00 && !cfg.mux16)
      |-> !pins.write_strobe_n;
  endproperty
  a_wr_delay0: assert property (p_wr_delay0) else $error("write strobe late with zero delay");

  property p_ale_in_cs;
    @(posedge clk_sys) disable iff (!nrst)
    pins.ale |-> (!pins.chip_select_n && pins.read_strobe_n && pins.write_strobe_n);
  endproperty
  a_ale_in_cs: assert property (p_ale_in_cs) else $error("latch enable overlaps strobe");

  property p_strobes_excl;
    @(posedge clk_sys) disable iff (!nrst)
    !(~pins.read_strobe_n & ~pins.write_strobe_n);
  endproperty
  a_strobes_excl: assert property (p_strobes_excl) else $error("both strobes active");

  property p_wr_len_min;
    @(posedge clk_sys) disable iff (!nrst)
    ($fell(pins.write_strobe_n) && !cfg.full_rate) |=> !pins.write_strobe_n;
  endproperty
  a_wr_len_min: assert property (p_wr_len_min) else $error("write strobe shorter than two cycles");

  property p_split_two;
    @(posedge clk_sys) disable iff (!nrst)
    (q.st == ST_HOLD && q.split && !q.second && next_q.st != ST_HOLD) |=> (q.st == ST_DLY && q.second);
  endproperty
  a_split_two: assert property (p_split_two) else $error("second byte cycle missing");
endmodule : embst_seq

// File: verif/embst_mem_model.sv
// Behavioural external static memory facing the strobe sequencer
`timescale 1ns/1ps
module embst_mem_model (
  input wire logic clk_sys,
  input embst_pkg::embst_pins_s pins,
  output logic [embst_pkg::EMBST_DATA_W-1:0] bus_rdata
);
  import embst_pkg::*;
  logic [EMBST_DATA_W-1:0] last = 16'h0000;
  logic active;
  assign active = !pins.chip_select_n && !pins.read_strobe_n;
  // Data only while strobed; a released bus shows the inverse so late sampling is caught
  assign bus_rdata = active ? (pins.addr[15:0] ^ 16'ha5c3) : ~last;
  always_ff @(posedge clk_sys) begin
    last <= bus_rdata;
  end
endmodule : embst_mem_model

// File: verif/tb.sv
// Self-checking bench for the external memory bus strobe sequencer
`timescale 1ns/1ps
module tb;
  import embst_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  embst_cfg_s cfg;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic req_wide = 1'b0;
  logic [23:0] req_addr = 24'h000000;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] bus_rdata, rdata;
  logic busy, done;
  embst_pins_s pins;
  int err_total = 0;
  int tests_run = 0;
  int ale_c, pre_c, str_c, post_c, pulses, oe_c;
  logic [23:0] addr_q [2];
  logic [7:0] data_q [2];
  always #25 clk_sys = ~clk_sys;
  embst_seq dut_u (.clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .req(req), .req_write(req_write),
    .req_wide(req_wide), .req_addr(req_addr), .req_wdata(req_wdata), .bus_rdata(bus_rdata), .busy(busy),
    .done(done), .rdata(rdata), .pins(pins));
  embst_mem_model mem_u (.clk_sys(clk_sys), .pins(pins), .bus_rdata(bus_rdata));
  // ====================
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic set_cfg(input logic fr, input logic mx, input logic [1:0] al, input logic [4:0] rw, rd, ww, wd);
    @(posedge clk_sys);
    cfg <= '{fr, mx, al, rw, rd, ww, wd};
  endtask : set_cfg
  // Samples at the rising edge, so pins show the values of the cycle just ended
  task automatic run_op(input logic w, input logic wide, input logic [23:0] a, input logic [15:0] d);
    int k;
    logic st;
    logic pst;
    ale_c = 0;
    pre_c = 0;
    str_c = 0;
    post_c = 0;
    pulses = 0;
    oe_c = 0;
    pst = 1'b1;
    k = 0;
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= w;
    req_wide <= wide;
    req_addr <= a;
    req_wdata <= d;
    do begin
      @(posedge clk_sys);
      if (busy === 1'b1) req <= 1'b0;
      st = w ? pins.write_strobe_n : pins.read_strobe_n;
      if (pins.ale === 1'b1) ale_c++;
      if (st === 1'b0) begin
        str_c++;
        // During a strobe, data lanes driven for a write and released for a read
        if (pins.data_oe_n !== ~w) oe_c++;
        if (pst === 1'b1 && pulses < 2) begin
          addr_q[pulses] = pins.addr;
          data_q[pulses] = pins.wdata[7:0];
          pulses++;
        end
      end else if (pins.chip_select_n === 1'b0) begin
        if (pulses == 0) pre_c++;
        else post_c++;
      end
      pst = st;
      k++;
    end while (done !== 1'b1 && k < 500);
    chk(24'(done), 24'h000001);
    chk(24'(oe_c), 24'd0);
    chk(24'(pins.data_oe_n), 24'd1);
  endtask : run_op
  // ====================
  // Scenarios
  task automatic sc_default_read();
    chk({19'h0, pins.chip_select_n, pins.read_strobe_n, pins.write_strobe_n, pins.ale, busy}, 24'h00001c);
    run_op(1'b0, 1'b0, 24'h00a512, 16'h0000);
    chk(24'(str_c), 24'd62);
    chk(24'(pre_c), 24'd2);
    chk(24'(post_c), 24'd0);
    chk(24'(rdata), 24'(16'ha512 ^ 16'ha5c3));
  endtask : sc_default_read
  task automatic sc_fast_read();
    set_cfg(1'b1, 1'b0, 2'h1, 5'h04, 5'h02, 5'h1f, 5'h00);
    run_op(1'b0, 1'b0, 24'h0b0c3e, 16'h0000);
    chk(24'(str_c), 24'd3);
    chk(24'(pre_c), 24'd2);
    chk(24'(post_c), 24'd0);
    chk(24'(rdata), 24'(16'h0c3e ^ 16'ha5c3));
    set_cfg(1'b1, 1'b0, 2'h1, 5'h04, 5'h00, 5'h1f, 5'h00);
    run_op(1'b0, 1'b0, 24'h000777, 16'h0000);
    chk(24'(str_c), 24'd5);
    chk(24'(pre_c), 24'd0);
    chk(24'(rdata), 24'(16'h0777 ^ 16'ha5c3));
  endtask : sc_fast_read
  task automatic sc_default_write();
    set_cfg(EMBST_RATIO_HALF, 1'b0, EMBST_ALE_LEN_RST, EMBST_RD_WAIT_RST, EMBST_RD_DELAY_RST, EMBST_WR_WAIT_RST,
      EMBST_WR_DELAY_RST);
    run_op(1'b1, 1'b0, 24'h123456, 16'h0077);
    chk(24'(str_c), 24'd64);
    chk(24'(pre_c), 24'd0);
    chk(24'(post_c), 24'd1);
    chk({addr_q[0]}, 24'h123456);
    chk(24'(data_q[0]), 24'h000077);
  endtask : sc_default_write
  task automatic sc_fast_write();
    set_cfg(1'b1, 1'b0, 2'h1, 5'h1f, 5'h01, 5'h03, 5'h02);
    run_op(1'b1, 1'b0, 24'h00fffe, 16'h00c4);
    chk(24'(str_c), 24'd2);
    chk(24'(pre_c), 24'd2);
    chk(24'(post_c), 24'd1);
  endtask : sc_fast_write
  task automatic sc_split_write();
    set_cfg(1'b1, 1'b0, 2'h1, 5'h1f, 5'h01, 5'h02, 5'h01);
    run_op(1'b1, 1'b1, 24'h001230, 16'hbe5a);
    chk(24'(pulses), 24'd2);
    chk(24'(str_c), 24'd4);
    chk(addr_q[0], 24'h001230);
    chk(addr_q[1], 24'h001231);
    chk({8'h00, data_q[1], data_q[0]}, 24'h00be5a);
  endtask : sc_split_write
  task automatic sc_mux_ale();
    set_cfg(1'b1, 1'b1, 2'h2, 5'h03, 5'h01, 5'h1f, 5'h00);
    run_op(1'b0, 1'b0, 24'h004321, 16'h0000);
    chk(24'(ale_c), 24'd2);
    chk(24'(rdata), 24'(16'h4321 ^ 16'ha5c3));
    set_cfg(1'b0, 1'b1, 2'h1, 5'h03, 5'h01, 5'h1f, 5'h00);
    run_op(1'b0, 1'b0, 24'h00789a, 16'h0000);
    chk(24'(ale_c), 24'd2);
    set_cfg(1'b1, 1'b1, 2'h2, 5'h03, 5'h01, 5'h1f, 5'h00);
    run_op(1'b1, 1'b1, 24'h002468, 16'h1357);
    chk(24'(pulses), 24'd1);
    chk(24'(ale_c), 24'd2);
    chk(24'(str_c), 24'd32);
    chk(addr_q[0], 24'h002468);
  endtask : sc_mux_ale
  // Reset in the middle of a read strobe, then a clean read
  task automatic sc_mid_reset();
    set_cfg(EMBST_RATIO_HALF, 1'b0, 2'h1, 5'h1f, 5'h01, 5'h1f, 5'h00);
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= 1'b0;
    req_wide <= 1'b0;
    req_addr <= 24'h00beef;
    repeat (8) @(posedge clk_sys);
    req <= 1'b0;
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({18'h0, pins.chip_select_n, pins.read_strobe_n, pins.write_strobe_n, pins.ale, busy, pins.data_oe_n},
      24'h000039);
    nrst <= 1'b1;
    run_op(1'b0, 1'b0, 24'h00beef, 16'h0000);
    chk(24'(str_c), 24'd62);
    chk(24'(pre_c), 24'd2);
    chk(24'(rdata), 24'(16'hbeef ^ 16'ha5c3));
  endtask : sc_mid_reset
  // ====================
  // Verdict and sequence
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    cfg = '{EMBST_RATIO_HALF, 1'b0, EMBST_ALE_LEN_RST, EMBST_RD_WAIT_RST, EMBST_RD_DELAY_RST, EMBST_WR_WAIT_RST,
      EMBST_WR_DELAY_RST};
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    sc_default_read();
    sc_fast_read();
    sc_default_write();
    sc_fast_write();
    sc_split_write();
    sc_mux_ale();
    sc_mid_reset();
    report_and_stop();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end
endmodule : tb
